//--- verilog/uart_fc_params.svh
`ifndef UART_FC_PARAMS_SVH
`define UART_FC_PARAMS_SVH
// Field positions
`define FCR_FIFO_EN     0
`define EFR_TX_TRIG_EN  4
`define EFR_AUTO_RTS    6
`define EFR_AUTO_CTS    7
`define IER_RX_DATA     0
`define IER_XOFF        5
`define IER_RTS         6
`define IER_CTS         7
`define ISR_XOFF        4
`define ISR_CTS_RTS     5
`define LCR_ENH_KEY     8'hBF
// Reset values
`define TX_TRIG_RESET   6'h10
`define XCHAR_RESET     8'h00
// Receive trigger table: trigger, off level, on level
`define LVL8_TRIG  6'h08
`define LVL8_OFF   6'h10
`define LVL8_ON    6'h00
`define LVL16_TRIG 6'h10
`define LVL16_OFF  6'h18
`define LVL16_ON   6'h07
`define LVL24_TRIG 6'h18
`define LVL24_OFF  6'h1C
`define LVL24_ON   6'h0F
`define LVL28_TRIG 6'h1C
`define LVL28_OFF  6'h1C
`define LVL28_ON   6'h17
// Time-out: four character times of about 10 bits
`define TIMEOUT_BITS 16'h0028
`endif

//--- verilog/uart_fc_pkg.sv
package uart_fc_pkg;
  typedef logic [5:0] level_t;
  typedef struct packed {
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
  } xchars_s;
  typedef struct packed {
    level_t trig;
    level_t off;
    level_t on;
  } levels_s;
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_HALF = 3'b010,
    SW_STOP = 3'b100
  } swState_e;
endpackage : uart_fc_pkg

//--- verilog/uart_fifo_flow_control.sv
`timescale 1ns/10ps
`include "uart_fc_params.svh"
// Functional notes
// - The 32-byte receive buffer acts as a FIFO only while the FIFO enable bit is set.
// - Transmit trigger level is 16 after reset.
// - Written transmit trigger is stored and used only while enhanced bit 4 is one; otherwise 16 applies.
// - Time-out interrupt when unread data sits below trigger level too long.
// - Receive triggers 8, 16, 24, 28; interrupt at selected fill.
// - Auto flow negates RTS at 16, 24, 28, 28; Xoff is sent above the trigger.
// - Auto flow asserts RTS at fill 0, 7, 15, 23; Xon is sent below the trigger.
// - Enhanced bit 6 enables auto RTS, bit 7 enables auto CTS.
// - Auto CTS rise stops transmission after current stop bit.
// - CTS request sets status bit 5 when enables 6 and 7 set.
// - Paused transmitter resumes when CTS returns low.
// - Trigger raises interrupt; RTS goes high at next higher level, at 28 itself for trigger 28.
// - RTS returns low when FIFO drains below next lower level, or to empty for trigger 8.
// - Receiver keeps accepting characters until the FIFO is full.
// - Software flow compares one or two characters with Xoff, then halts.
// - Xoff match sets status flag if enabled, drives interrupt if enabled.
// - While suspended, Xon match resumes and clears status bit 4.
// - Reset clears the four flow-control character registers.
// - Double mode compares two consecutive characters against the pair.
// - Recognised flow-control characters are not stored in the FIFO.
// - Enhanced and character registers writable only when line control is BF; efrOut reads zero otherwise, xchars always shows the characters.
// - Auto software flow sends Xoff above trigger, Xon below it.
module uart_fifo_flow_control #(
  parameter int DEPTH = 32,
  parameter int TIMEOUT_TICKS = 40
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Host register writes (one-cycle strobes with data)
  input  wire logic [7:0]            lineControl,
  input  wire logic                  fcrWrite,
  input  wire logic [7:0]            fcrData,
  input  wire logic                  efrWrite,
  input  wire logic                  xcharWrite,
  input  wire logic [1:0]            xcharSel,
  input  wire logic [7:0]            regData,
  input  wire logic [7:0]            interruptEnable,
  input  wire logic                  swDouble,
  input  wire logic                  isrXoffClear,
  input  wire logic                  isrCtsClear,
  // Receive path
  input  wire logic                  rxValid,
  input  wire logic [7:0]            rxChar,
  input  wire logic                  rxRead,
  input  wire logic                  bitTick,
  // Transmit side and line pins
  input  wire logic                  txCharDone,
  input  wire logic [5:0]            txLevel,
  input  wire logic                  ctsPin_n,
  // Outputs
  output logic                       fifoMode,
  output logic [7:0]                 rxData,
  output logic [5:0]                 rxCount,
  output logic                       rxTrigger,
  output logic                       rxTimeout,
  output logic                       txTrigger,
  output logic                       txHalt,
  output logic                       rts_n,
  output logic                       sendXoff,
  output logic                       sendXon,
  output logic [7:0]                 efrOut,
  output uart_fc_pkg::xchars_s       xchars,
  output logic [7:0]                 isrFlags,
  output logic                       irq
);

  // Storage and state
  logic [7:0]                 mem [DEPTH];
  logic [4:0]                 wrPtr_q, rdPtr_q;
  logic [5:0]                 cnt_q;
  logic [7:0]                 fcr_q, efr_q, prev_q;
  logic [5:0]                 txTrig_q;
  uart_fc_pkg::xchars_s       xc_q;
  uart_fc_pkg::swState_e      sw_q;
  logic                       cts1_q, cts2_q, cts3_q;
  logic                       ctsStop_q, ctsPend_q, rtsOff_q, xoffSent_q;
  logic                       isrX_q, isrC_q;
  logic [15:0]                tmo_q;
  logic                       tmoFlag_q;

  // Level table decode, used for both directions
  function automatic uart_fc_pkg::levels_s lvl(input logic [1:0] sel);
    case (sel)
      2'd0:    lvl = '{`LVL8_TRIG,  `LVL8_OFF,  `LVL8_ON};
      2'd1:    lvl = '{`LVL16_TRIG, `LVL16_OFF, `LVL16_ON};
      2'd2:    lvl = '{`LVL24_TRIG, `LVL24_OFF, `LVL24_ON};
      default: lvl = '{`LVL28_TRIG, `LVL28_OFF, `LVL28_ON};
    endcase
  endfunction : lvl

  // Decode
  wire uart_fc_pkg::levels_s rxLvl = lvl(fcr_q[7:6]);
  wire uart_fc_pkg::levels_s txSel = lvl(fcr_q[5:4]);
  // Level chosen by the write in flight, so the stored trigger needs no second cycle
  wire uart_fc_pkg::levels_s wrTxLvl = lvl(fcrData[5:4]);
  wire enhOpen   = (lineControl == `LCR_ENH_KEY);
  wire fifoEn    = fcr_q[`FCR_FIFO_EN];
  wire [5:0] cap = fifoEn ? 6'(DEPTH) : 6'h01;
  wire swEn      = (efr_q[3:0] != 4'h0);
  wire autoRts   = efr_q[`EFR_AUTO_RTS];
  wire autoCts   = efr_q[`EFR_AUTO_CTS];
  wire xoffFirst = (rxChar == xc_q.xoff1);
  wire xonFirst  = (rxChar == xc_q.xon1);
  wire xoffHit   = swEn && rxValid && (swDouble ? (sw_q == uart_fc_pkg::SW_HALF && prev_q == xc_q.xoff1
                     && rxChar == xc_q.xoff2) : xoffFirst);
  wire xonHit    = swEn && rxValid && (swDouble ? (prev_q == xc_q.xon1 && rxChar == xc_q.xon2) : xonFirst);
  // flow-control characters are filtered out of the FIFO
  wire isCtl     = swEn && rxValid && (xoffFirst || xonFirst || xoffHit || xonHit);
  wire doWr      = rxValid && !isCtl && (cnt_q < cap);
  wire doRd      = rxRead && (cnt_q != 6'h00);
  wire ctsRise   = cts2_q && !cts3_q;

  // Receive FIFO storage
  always_ff @(posedge clk) begin
    if (doWr)
      mem[wrPtr_q] <= rxChar;
  end

  // Pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= 5'h00;
      rdPtr_q <= 5'h00;
      cnt_q   <= 6'h00;
      rxData  <= 8'h00;
    end else begin
      if (doWr)
        wrPtr_q <= fifoEn ? wrPtr_q + 5'h01 : wrPtr_q;
      if (doRd) begin
        rdPtr_q <= fifoEn ? rdPtr_q + 5'h01 : rdPtr_q;
        rxData  <= mem[rdPtr_q];
      end
      cnt_q <= cnt_q + 6'(doWr) - 6'(doRd);
    end
  end

  // Host configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fcr_q    <= 8'h00;
      efr_q    <= 8'h00;
      xc_q     <= '{`XCHAR_RESET, `XCHAR_RESET, `XCHAR_RESET, `XCHAR_RESET};
      txTrig_q <= `TX_TRIG_RESET;
    end else begin
      if (fcrWrite)
        fcr_q <= fcrData;
      // stored trigger applies only when enabled
      if (fcrWrite && efr_q[`EFR_TX_TRIG_EN])
        txTrig_q <= wrTxLvl.trig;
      else if (!efr_q[`EFR_TX_TRIG_EN])
        txTrig_q <= `TX_TRIG_RESET;
      if (efrWrite && enhOpen)
        efr_q <= regData;
      if (xcharWrite && enhOpen) begin
        case (xcharSel)
          2'd0:    xc_q.xon1  <= regData;
          2'd1:    xc_q.xon2  <= regData;
          2'd2:    xc_q.xoff1 <= regData;
          default: xc_q.xoff2 <= regData;
        endcase
      end
    end
  end

  // CTS pin synchroniser and edge stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cts1_q <= 1'b0;
      cts2_q <= 1'b0;
      cts3_q <= 1'b0;
    end else begin
      cts1_q <= ctsPin_n;
      cts2_q <= cts1_q;
      cts3_q <= cts2_q;
    end
  end

  // Hardware flow control; a pending stop waits for the character end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctsPend_q  <= 1'b0;
      ctsStop_q  <= 1'b0;
      rtsOff_q   <= 1'b0;
      isrC_q     <= 1'b0;
    end else begin
      if (autoCts && ctsRise)
        ctsPend_q <= 1'b1;
      else if (txCharDone || !cts2_q)
        ctsPend_q <= 1'b0;
      if (autoCts && cts2_q && (ctsPend_q || ctsRise) && txCharDone)
        ctsStop_q <= 1'b1;
      else if (!cts2_q || !autoCts)
        ctsStop_q <= 1'b0;
      if (!autoRts)
        rtsOff_q <= 1'b0;
      else if (cnt_q >= rxLvl.off)
        rtsOff_q <= 1'b1;
      else if (cnt_q <= rxLvl.on)
        rtsOff_q <= 1'b0;
      if (autoCts && ctsRise && interruptEnable[`IER_CTS] && interruptEnable[`IER_RTS])
        isrC_q <= 1'b1;
      else if (isrCtsClear)
        isrC_q <= 1'b0;
    end
  end

  // Software flow control state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_q       <= uart_fc_pkg::SW_IDLE;
      prev_q     <= 8'h00;
      isrX_q     <= 1'b0;
      xoffSent_q <= 1'b0;
      sendXoff   <= 1'b0;
      sendXon    <= 1'b0;
    end else begin
      if (rxValid)
        prev_q <= rxChar;
      case (sw_q)
        uart_fc_pkg::SW_IDLE: if (xoffHit) sw_q <= uart_fc_pkg::SW_STOP;
                              else if (swDouble && rxValid && xoffFirst) sw_q <= uart_fc_pkg::SW_HALF;
        uart_fc_pkg::SW_HALF: if (xoffHit) sw_q <= uart_fc_pkg::SW_STOP;
                              else if (rxValid) sw_q <= uart_fc_pkg::SW_IDLE;
        uart_fc_pkg::SW_STOP: if (xonHit || !swEn) sw_q <= uart_fc_pkg::SW_IDLE;
        default:              sw_q <= uart_fc_pkg::SW_IDLE;
      endcase
      if (xoffHit && interruptEnable[`IER_XOFF])
        isrX_q <= 1'b1;
      else if ((sw_q == uart_fc_pkg::SW_STOP && xonHit) || isrXoffClear)
        isrX_q <= 1'b0;
      // send Xoff above trigger, Xon when below
      sendXoff <= swEn && !xoffSent_q && (cnt_q > rxLvl.trig);
      sendXon  <= swEn && xoffSent_q && (cnt_q < rxLvl.trig);
      if (swEn && !xoffSent_q && cnt_q > rxLvl.trig)
        xoffSent_q <= 1'b1;
      else if (!swEn || cnt_q < rxLvl.trig)
        xoffSent_q <= 1'b0;
    end
  end

  // Receive time-out counter, restarted by each FIFO write or read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmo_q     <= 16'h0000;
      tmoFlag_q <= 1'b0;
    end else if (doWr || doRd || cnt_q == 6'h00) begin
      tmo_q     <= 16'h0000;
      tmoFlag_q <= 1'b0;
    end else if (bitTick && cnt_q < rxLvl.trig) begin
      if (tmo_q >= 16'(TIMEOUT_TICKS - 1))
        tmoFlag_q <= 1'b1;
      else
        tmo_q <= tmo_q + 16'h0001;
    end
  end

  // Outputs
  assign fifoMode  = fifoEn;
  assign rxCount   = cnt_q;
  assign rxTrigger = fifoEn ? (cnt_q >= rxLvl.trig) : (cnt_q != 6'h00);
  assign rxTimeout = tmoFlag_q;
  assign txTrigger = (txLevel <= (6'(DEPTH) - txTrig_q));
  assign txHalt    = ctsStop_q || (sw_q == uart_fc_pkg::SW_STOP);
  assign rts_n     = rtsOff_q;
  assign efrOut    = enhOpen ? efr_q : 8'h00;
  assign xchars    = xc_q;
  assign isrFlags  = {2'b00, isrC_q, isrX_q, 4'h0};
  assign irq       = (interruptEnable[`IER_RX_DATA] && (rxTrigger || rxTimeout || isrX_q)) || isrC_q;

endmodule : uart_fifo_flow_control

//--- dv/uart_fc_monitor.sv
`timescale 1ns/10ps
`include "uart_fc_params.svh"
module uart_fc_monitor #(
  parameter int DEPTH         = 32,
  parameter int TIMEOUT_TICKS = 40
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Host side
  input wire logic [7:0]           lineControl,
  input wire logic                 fcrWrite,
  input wire logic [7:0]           fcrData,
  input wire logic                 xcharWrite,
  input wire logic [1:0]           xcharSel,
  input wire logic [7:0]           regData,
  input wire logic                 rxValid,
  input wire logic                 rxRead,
  input wire logic                 ctsPin_n,
  // Design outputs
  input wire logic                 fifoMode,
  input wire logic [5:0]           rxCount,
  input wire logic                 rxTrigger,
  input wire logic                 txHalt,
  input wire logic                 rts_n,
  input wire logic [7:0]           efrOut,
  input wire uart_fc_pkg::xchars_s xchars
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Plain receive: no flow-control decode in the way
  wire plainRx = (lineControl == `LCR_ENH_KEY) && (efrOut[3:0] == 4'h0);
  sequence autoRtsAt(logic [5:0] n, logic hi);
    efrOut[`EFR_AUTO_RTS] && (hi ? rxCount >= n : rxCount == n) ##1 efrOut[`EFR_AUTO_RTS];
  endsequence
  // Pin low long enough to pass the synchroniser
  sequence ctsClear;
    (!ctsPin_n && efrOut[`EFR_AUTO_CTS] && efrOut[3:0] == 4'h0) [*5];
  endsequence
  a_efr_locked: assert property (
    lineControl != `LCR_ENH_KEY |-> efrOut == 8'h00) else $error("enhanced view open while locked");
  a_xchar_locked: assert property (
    lineControl != `LCR_ENH_KEY |=> $stable(xchars)) else $error("flow characters changed while locked");
  a_xoff_write: assert property (
    lineControl == `LCR_ENH_KEY && xcharWrite && xcharSel == 2'h2 |=> xchars.xoff1 == $past(regData))
    else $error("first stop character not stored");
  a_fifo_enable: assert property (
    fcrWrite |=> fifoMode == $past(fcrData[`FCR_FIFO_EN])) else $error("FIFO mode does not follow bit 0");
  a_rx_accept: assert property (
    rxValid && !rxRead && !fcrWrite && fifoMode && plainRx && rxCount < DEPTH |=> rxCount == $past(rxCount) + 6'h01)
    else $error("character not accepted");
  a_fill_bound: assert property (
    rxCount <= DEPTH) else $error("fill above depth");
  a_rts_empty: assert property (
    autoRtsAt(6'h00, 1'b0) |-> !rts_n) else $error("request line not low when empty");
  a_rts_full: assert property (
    autoRtsAt(6'h1C, 1'b1) |-> rts_n) else $error("request line not high at top level");
  a_rx_trigger: assert property (
    (fifoMode && rxCount == 6'h20) [*2] |-> rxTrigger) else $error("trigger missing when full");
  a_cts_resume: assert property (
    ctsClear |-> !txHalt) else $error("transmitter still halted after clear");
endmodule : uart_fc_monitor

//--- dv/remote_serial_model.sv
`timescale 1ns/10ps
// Far-end device: hands received characters and drives the clear-to-send pin
module remote_serial_model (
  // Clock
  input wire logic clk,
  // Line side
  output logic       rxValid,
  output logic [7:0] rxChar,
  output logic       ctsPin_n
);
  initial begin
    rxValid  = 1'b0;
    rxChar   = 8'hA5;
    ctsPin_n = 1'b0;
  end
  // payload never flow values
  // Between characters the data shows the inverse, so stale values never match
  task send(input logic [7:0] c);
    @(negedge clk);
    rxValid = 1'b1;
    rxChar  = c;
    @(negedge clk);
    rxValid = 1'b0;
    rxChar  = ~c;
  endtask : send
  task cts(input logic v);
    @(negedge clk);
    ctsPin_n = v;
  endtask : cts
endmodule : remote_serial_model

//--- dv/tb_uart_fifo_flow_control.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errCount++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_uart_fifo_flow_control;
  // Stimulus and observed signals
  logic                 clk, rst, fcrWrite, efrWrite, xcharWrite, swDouble, rxRead, bitTick, txCharDone;
  logic [7:0]           lineControl, fcrData, regData, interruptEnable, rxData, efrOut, isrFlags;
  logic [1:0]           xcharSel;
  logic [5:0]           rxCount;
  logic                 rxValid, ctsPin_n, fifoMode, rxTrigger, rxTimeout, txHalt, rts_n, irq;
  logic [7:0]           rxChar;
  logic                 isrXoffClear, isrCtsClear, txTrigger, sendXoff, sendXon, seenXoff, seenXon;
  logic [5:0]           txLevel;
  uart_fc_pkg::xchars_s xchars;
  int                   errCount, comparisons, cycles, l, i;
  int                   offLvl[4] = '{16, 24, 28, 28};
  int                   onLvl[4]  = '{0, 7, 15, 23};
  // Short time-out keeps the idle wait brief
  uart_fifo_flow_control #(.TIMEOUT_TICKS(4)) dut (.clk(clk), .rst(rst), .lineControl(lineControl),
    .fcrWrite(fcrWrite), .fcrData(fcrData), .efrWrite(efrWrite), .xcharWrite(xcharWrite), .xcharSel(xcharSel),
    .regData(regData), .interruptEnable(interruptEnable), .swDouble(swDouble), .isrXoffClear(isrXoffClear),
    .isrCtsClear(isrCtsClear), .rxValid(rxValid), .rxChar(rxChar), .rxRead(rxRead), .bitTick(bitTick),
    .txCharDone(txCharDone), .txLevel(txLevel), .ctsPin_n(ctsPin_n), .fifoMode(fifoMode), .rxData(rxData),
    .rxCount(rxCount), .rxTrigger(rxTrigger), .rxTimeout(rxTimeout), .txTrigger(txTrigger), .txHalt(txHalt),
    .rts_n(rts_n), .sendXoff(sendXoff), .sendXon(sendXon), .efrOut(efrOut), .xchars(xchars),
    .isrFlags(isrFlags), .irq(irq));
  // One-cycle flow requests are caught in sticky flags
  always @(posedge clk) begin
    if (sendXoff)
      seenXoff = 1'b1;
    if (sendXon)
      seenXon = 1'b1;
  end
  remote_serial_model partner (.clk(clk), .rxValid(rxValid), .rxChar(rxChar), .ctsPin_n(ctsPin_n));
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Register write: kind 0 FIFO control, 1 enhanced, 2 flow character
  task wr(input int k, input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    {regData, fcrData, xcharSel} = {d, d, s};
    {fcrWrite, efrWrite, xcharWrite} = {k == 0, k == 1, k == 2};
    @(negedge clk);
    {fcrWrite, efrWrite, xcharWrite} = 3'h0;
  endtask : wr
  task rd(input logic [7:0] e);
    rxRead = 1'b1;
    @(negedge clk);
    `CHK("rxData", e, rxData)
    rxRead = 1'b0;
  endtask : rd
  task strobe(input bit done);
    {txCharDone, bitTick} = {done, !done};
    tick(1);
    {txCharDone, bitTick} = 2'h0;
    tick(2);
  endtask : strobe
  task end_sim;
    $display("checks %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Clock and a watchdog well above the expected run
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      end_sim();
    end
  end
  initial begin
    {rst, fcrWrite, efrWrite, xcharWrite, swDouble, rxRead, bitTick, txCharDone} = 8'h80;
    {lineControl, fcrData, regData, interruptEnable, xcharSel} = 34'h0;
    {isrXoffClear, isrCtsClear, seenXoff, seenXon} = 4'h0;
    txLevel = 6'h10;
    tick(16);
    rst = 1'b0;
    tick(1);
    `CHK("xchars", 32'h0, xchars)
    `CHK("txTrigger", 1'b1, txTrigger)
    txLevel = 6'h11;
    tick(1);
    `CHK("txTrigger", 1'b0, txTrigger)
    wr(1, 2'h0, 8'hFF);
    lineControl = 8'hBF;
    tick(1);
    `CHK("efrOut", 8'h00, efrOut)
    wr(1, 2'h0, 8'hC0);
    `CHK("efrOut", 8'hC0, efrOut)
    $display("test registers done");
    // Every receive level: fill past full, then drain in order
    for (l = 0; l < 4; l++) begin
      wr(0, 2'h0, 8'(l * 64 + 1));
      for (i = 1; i <= 33; i++) begin
        partner.send(8'(64 + i));
        tick(2);
        `CHK("rts_n", i >= offLvl[l], rts_n)
        `CHK("rxTrigger", i >= 8 * l + 8 - (l == 3 ? 4 : 0), rxTrigger)
      end
      `CHK("rxCount", 6'h20, rxCount)
      for (i = 1; i <= 32; i++) begin
        rd(8'(64 + i));
        tick(2);
        `CHK("rts_n", 32 - i > onLvl[l], rts_n)
      end
    end
    $display("test levels done");
    partner.send(8'h55);
    strobe(0);
    `CHK("rxTimeout", 1'b0, rxTimeout)
    repeat (8) strobe(0);
    `CHK("rxTimeout", 1'b1, rxTimeout)
    rd(8'h55);
    $display("test time-out done");
    interruptEnable = 8'hC0;
    partner.cts(1'b1);
    tick(5);
    strobe(1);
    `CHK("txHalt", 1'b1, txHalt)
    `CHK("isrFlags5", 1'b1, isrFlags[5])
    partner.cts(1'b0);
    tick(6);
    `CHK("txHalt", 1'b0, txHalt)
    isrCtsClear = 1'b1;
    tick(1);
    isrCtsClear = 1'b0;
    `CHK("isrFlags5", 1'b0, isrFlags[5])
    wr(0, 2'h0, 8'h01);
    `CHK("txTrigger", 1'b0, txTrigger)
    wr(1, 2'h0, 8'h10);
    wr(0, 2'h0, 8'hC1);
    txLevel = 6'h18;
    tick(1);
    `CHK("txTrigger", 1'b1, txTrigger)
    txLevel = 6'h19;
    tick(1);
    `CHK("txTrigger", 1'b0, txTrigger)
    $display("test cts done");
    wr(1, 2'h0, 8'h0A);
    for (i = 0; i < 4; i++) wr(2, 2'(i), 8'(17 + i));
    `CHK("xchars", 32'h11121314, xchars)
    interruptEnable = 8'h21;
    // Single then double character matching
    for (l = 0; l < 2; l++) begin
      swDouble = l[0];
      partner.send(8'h13);
      if (l == 1) partner.send(8'h14);
      strobe(1);
      `CHK("txHalt", 1'b1, txHalt)
      `CHK("isrFlags4", 1'b1, isrFlags[4])
      `CHK("irq", 1'b1, irq)
      if (l == 1) begin
        isrXoffClear = 1'b1;
        tick(1);
        isrXoffClear = 1'b0;
        `CHK("isrFlags4", 1'b0, isrFlags[4])
      end
      partner.send(8'h11);
      if (l == 1) partner.send(8'h12);
      tick(3);
      `CHK("txHalt", 1'b0, txHalt)
      `CHK("isrFlags4", 1'b0, isrFlags[4])
      `CHK("rxCount", 6'h00, rxCount)
    end
    // Fill past the trigger for Xoff, then drain below it for Xon
    {seenXoff, seenXon} = 2'h0;
    for (i = 1; i <= 29; i++) partner.send(8'(64 + i));
    tick(2);
    `CHK("seenXoff", 1'b1, seenXoff)
    `CHK("seenXon", 1'b0, seenXon)
    for (i = 1; i <= 29; i++) rd(8'(64 + i));
    tick(2);
    `CHK("seenXon", 1'b1, seenXon)
    $display("test software flow done");
    end_sim();
  end
endmodule : tb_uart_fifo_flow_control
bind uart_fifo_flow_control uart_fc_monitor #(.DEPTH(DEPTH), .TIMEOUT_TICKS(TIMEOUT_TICKS)) mon (.clk(clk),
  .rst(rst), .lineControl(lineControl), .fcrWrite(fcrWrite), .fcrData(fcrData), .xcharWrite(xcharWrite),
  .xcharSel(xcharSel), .regData(regData), .rxValid(rxValid), .rxRead(rxRead), .ctsPin_n(ctsPin_n),
  .fifoMode(fifoMode), .rxCount(rxCount), .rxTrigger(rxTrigger), .txHalt(txHalt), .rts_n(rts_n),
  .efrOut(efrOut), .xchars(xchars));
